// ===== inc/stop_cmd_defines.svh
// Bit positions, offsets and widths shared by both ends of the link
`ifndef STOP_CMD_DEFINES_SVH
`define STOP_CMD_DEFINES_SVH
`define LINK_POINTS 64
`define WORD_W 16
`define POS_W 32
// Cyclic bits, word n+3 of the 64-point area (n taken as 0 here)
`define BIT_TGT_REQ 48
`define BIT_ACC_REQ 53
`define BIT_DEC_REQ 55
`define BIT_FLT_CLR 58
`define BIT_TGT_DONE 48
`define BIT_TGT_REJ 49
// Controller APB map
`define OFS_CTRL 8'h00
`define OFS_TARGET 8'h04
`define OFS_STATUS 8'h08
`define OFS_ACTIVE 8'h0c
`define OFS_POSITION 8'h10
`define OFS_AUX 8'h14
`define CTRL_GO 0
`define ST_BUSY 0
`define ST_DONE 1
`define ST_REJ 2
`define AUX_ACC 0
`define AUX_DEC 1
`define AUX_FLT 2
`endif

// ===== inc/stop_cmd_pkg.sv
// Types shared by both ends of the stop-position link
package stop_cmd_pkg;
  typedef enum logic [1:0] {DEV_IDLE, DEV_CHECK, DEV_DONE} dev_state_t;
  typedef enum logic [1:0] {
    MST_IDLE, MST_LOAD, MST_REQ, MST_RELEASE
  } mst_state_t;
  typedef logic signed [31:0] pos_t;
endpackage

// ===== inc/stop_link_if.sv
// Cyclic bit area and register words between master and drive
`timescale 1ns/100ps
`include "stop_cmd_defines.svh"
interface stop_link_if;
  logic [`LINK_POINTS-1:0] ry;
  logic [`LINK_POINTS-1:0] rx;
  logic [`WORD_W-1:0] target_position_low_word;
  logic [`WORD_W-1:0] target_position_high_word;
  logic [`WORD_W-1:0] active_target_low_word;
  logic [`WORD_W-1:0] active_target_high_word;
  logic [`WORD_W-1:0] present_position_low_word;
  logic [`WORD_W-1:0] present_position_high_word;
  modport device (
    input ry, target_position_low_word, target_position_high_word,
    output rx, active_target_low_word, active_target_high_word,
    output present_position_low_word, present_position_high_word
  );
  modport master (
    output ry, target_position_low_word, target_position_high_word,
    input rx, active_target_low_word, active_target_high_word,
    input present_position_low_word, present_position_high_word
  );
endinterface

// ===== hw/stop_cmd_device.sv
// Drive end: stop-position target intake, validation and monitor words
// Overview of operation
// RULE_01 - Target is signed 32-bit, low/high words
// RULE_02 - Out-of-range target rejected, previous kept
// RULE_03 - Words loaded first, copied on request
// RULE_04 - Master reads done and rejected flags
// RULE_05 - Active target returned in read words 4/5
// RULE_06 - Present position returned in words 6/7
// RULE_07 - Position from dual feedback or filter
// RULE_08 - Cyclic bit area fixed at 64 points
// RULE_09 - Target request is bit 0 of n+3
// RULE_10 - Accel request is bit 5 of n+3
// RULE_11 - Decel request bit 7; 6,8,9 reserved
// RULE_12 - Fault clear bit A; B..F reserved
// RULE_13 - Done set after check, cleared on release
// RULE_14 - Reject during decel or unreachable point
// RULE_15 - Rejected cleared on release, low if accepted
// RULE_16 - Both words captured together on request edge
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`include "stop_cmd_defines.svh"
module stop_cmd_device
  import stop_cmd_pkg::*;
#(
  parameter int POS_W = `POS_W
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  stop_link_if.device link,
  input wire logic signed [POS_W-1:0] travel_limit_one,
  input wire logic signed [POS_W-1:0] travel_limit_two,
  input wire logic vector_ctrl,
  input wire logic signed [POS_W-1:0] dual_fb_position,
  input wire logic signed [POS_W-1:0] filter_position,
  input wire logic running,
  input wire logic decelerating,
  input wire logic signed [POS_W-1:0] reach_min,
  input wire logic signed [POS_W-1:0] reach_max,
  output logic signed [POS_W-1:0] active_target,
  output logic target_update,
  output logic accel_write_request,
  output logic decel_write_request,
  output logic fault_clear_request
);
  dev_state_t state_q, state_d;
  logic req_q;
  logic signed [POS_W-1:0] cand_q;
  logic signed [POS_W-1:0] active_q;
  logic signed [POS_W-1:0] pos_q;
  logic done_q;
  logic rej_q;
  logic upd_q;
  logic acc_q;
  logic dec_q;
  logic flt_q;

  // Limits may be given in either order
  function automatic logic in_span(input logic signed [POS_W-1:0] v,
                                   input logic signed [POS_W-1:0] a,
                                   input logic signed [POS_W-1:0] b);
    logic signed [POS_W-1:0] lo;
    logic signed [POS_W-1:0] hi;
    lo = (a < b) ? a : b;
    hi = (a < b) ? b : a;
    in_span = (v >= lo) && (v <= hi);
  endfunction

  // Word halves as the link carries them, low half first
  function automatic logic [`WORD_W-1:0] half_word(
      input logic signed [POS_W-1:0] v,
      input logic upper);
    half_word = upper ? v[POS_W-1:`WORD_W] : v[`WORD_W-1:0];
  endfunction

  wire req_in = link.ry[`BIT_TGT_REQ]; // see RULE_09
  // Rising edge only: a held request does not re-trigger
  wire req_rise = req_in & ~req_q;
  // Strobes of the three handshake steps
  wire take = (state_q == DEV_IDLE) & req_rise;
  wire judge = state_q == DEV_CHECK;
  wire release_seen = (state_q == DEV_DONE) & ~req_in;
  wire [POS_W-1:0] cand_words =
    {link.target_position_high_word,
     link.target_position_low_word}; // see RULE_01
  wire limit_ok =
    in_span(cand_q, travel_limit_one, travel_limit_two); // see RULE_02
  wire reach_ok =
    ~running | in_span(cand_q, reach_min, reach_max); // see RULE_14
  // Any one reason is enough to keep the old target
  wire accept = limit_ok & reach_ok & ~decelerating; // see RULE_14
  wire signed [POS_W-1:0] pos_sel =
    vector_ctrl ? dual_fb_position : filter_position; // see RULE_07

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DEV_IDLE: begin
        if (req_rise) begin
          state_d = DEV_CHECK;
        end
      end
      DEV_CHECK: begin
        state_d = DEV_DONE;
      end
      DEV_DONE: begin
        if (!req_in) begin
          state_d = DEV_IDLE;
        end
      end
      default: begin
        state_d = DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= DEV_IDLE;
      req_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= req_in;
    end
  end

  // Both halves taken in one edge, so a half-updated pair is never used
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cand_q <= '0;
    end else if (take) begin
      cand_q <= cand_words; // see RULE_16 see RULE_03
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      active_q <= '0;
      upd_q <= 1'b0;
    end else begin
      upd_q <= 1'b0;
      if (judge && accept) begin
        active_q <= cand_q; // see RULE_02 see RULE_03
        upd_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 1'b0;
    end else if (judge) begin
      done_q <= 1'b1; // see RULE_13
    end else if (release_seen) begin
      done_q <= 1'b0; // see RULE_13
    end
  end

  // Verdict kept apart from receipt; both fall together on release
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rej_q <= 1'b0;
    end else if (judge) begin
      rej_q <= ~accept; // see RULE_15 see RULE_02
    end else if (release_seen) begin
      rej_q <= 1'b0; // see RULE_15
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pos_q <= '0;
    end else begin
      pos_q <= pos_sel; // see RULE_07
    end
  end

  // Other write requests are only passed on as levels to the drive core
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= 1'b0;
      dec_q <= 1'b0;
      flt_q <= 1'b0;
    end else begin
      acc_q <= link.ry[`BIT_ACC_REQ]; // see RULE_10
      dec_q <= link.ry[`BIT_DEC_REQ]; // see RULE_11
      flt_q <= link.ry[`BIT_FLT_CLR]; // see RULE_12
    end
  end

  // Only two status bits are in scope; the rest of the area reads zero
  always_comb begin
    link.rx = '0; // see RULE_08
    link.rx[`BIT_TGT_DONE] = done_q; // see RULE_13
    link.rx[`BIT_TGT_REJ] = rej_q; // see RULE_15
  end

  assign link.active_target_low_word =
    half_word(active_q, 1'b0); // see RULE_05
  assign link.active_target_high_word =
    half_word(active_q, 1'b1); // see RULE_05
  assign link.present_position_low_word =
    half_word(pos_q, 1'b0); // see RULE_06
  assign link.present_position_high_word =
    half_word(pos_q, 1'b1); // see RULE_06

  assign active_target = active_q;
  assign target_update = upd_q;
  assign accel_write_request = acc_q;
  assign decel_write_request = dec_q;
  assign fault_clear_request = flt_q;
endmodule

// ===== hw/stop_cmd_master.sv
// Controller end: APB registers driving the stop-position handshake
`timescale 1ns/100ps
`include "stop_cmd_defines.svh"
module stop_cmd_master
  import stop_cmd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  stop_link_if.master link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  mst_state_t state_q;
  logic [31:0] target_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic req_q;
  logic done_q, rej_q;
  logic [2:0] aux_q;
  logic [31:0] lo_hi_q;

  wire setup = psel & ~penable & ~pready_q;
  wire acc = psel & penable & pready_q;
  wire wr = acc & pwrite;
  wire hit_ctrl = paddr == `OFS_CTRL;
  wire hit_tgt = paddr == `OFS_TARGET;
  wire hit_st = paddr == `OFS_STATUS;
  wire hit_act = paddr == `OFS_ACTIVE;
  wire hit_pos = paddr == `OFS_POSITION;
  wire hit_aux = paddr == `OFS_AUX;
  wire mapped = hit_ctrl | hit_tgt | hit_st | hit_act | hit_pos | hit_aux;
  wire go = wr & hit_ctrl & pwdata[`CTRL_GO] & (state_q == MST_IDLE);
  wire busy = state_q != MST_IDLE;
  wire [31:0] act_word = {link.active_target_high_word,
                          link.active_target_low_word};
  wire [31:0] pos_word = {link.present_position_high_word,
                          link.present_position_low_word};
  wire [31:0] rd_mux =
    hit_tgt ? target_q :
    hit_st ? {29'h0, rej_q, done_q, busy} :
    hit_act ? act_word :
    hit_pos ? pos_word :
    hit_aux ? {29'h0, aux_q} : 32'h0;

  // No wait state: data is registered in setup, ready in access
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      target_q <= 32'h0;
      aux_q <= 3'h0;
    end else begin
      if (wr & hit_tgt & ~busy) begin
        target_q <= pwdata; // see RULE_01
      end
      if (wr & hit_aux) begin
        aux_q <= pwdata[2:0];
      end
    end
  end

  // Words first, request next cycle, then wait for the drive's receipt
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= MST_IDLE;
      req_q <= 1'b0;
      lo_hi_q <= 32'h0;
      done_q <= 1'b0;
      rej_q <= 1'b0;
    end else begin
      unique case (state_q)
        MST_IDLE: begin
          if (go) begin
            lo_hi_q <= target_q; // see RULE_03
            done_q <= 1'b0;
            state_q <= MST_LOAD;
          end
        end
        MST_LOAD: begin
          req_q <= 1'b1; // see RULE_03
          state_q <= MST_REQ;
        end
        MST_REQ: begin
          if (link.rx[`BIT_TGT_DONE]) begin
            rej_q <= link.rx[`BIT_TGT_REJ]; // see RULE_04
            req_q <= 1'b0;
            state_q <= MST_RELEASE;
          end
        end
        MST_RELEASE: begin
          if (!link.rx[`BIT_TGT_DONE]) begin
            done_q <= 1'b1; // see RULE_04
            state_q <= MST_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    link.ry = '0; // see RULE_08
    link.ry[`BIT_TGT_REQ] = req_q; // see RULE_09
    link.ry[`BIT_ACC_REQ] = aux_q[`AUX_ACC]; // see RULE_10
    link.ry[`BIT_DEC_REQ] = aux_q[`AUX_DEC]; // see RULE_11
    link.ry[`BIT_FLT_CLR] = aux_q[`AUX_FLT]; // see RULE_12
  end

  assign link.target_position_low_word = lo_hi_q[`WORD_W-1:0];
  assign link.target_position_high_word = lo_hi_q[31:`WORD_W];
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule

// ===== verification/stop_link_checker.sv
// Assertions on the link between master and drive ends
`timescale 1ns/100ps
`include "stop_cmd_defines.svh"
module stop_link_checker (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [63:0] ry,
  input wire logic [63:0] rx,
  input wire logic [15:0] target_position_low_word,
  input wire logic [15:0] target_position_high_word,
  input wire logic [15:0] active_target_low_word,
  input wire logic [15:0] active_target_high_word
);
  logic [31:0] cap_q;
  wire [31:0] act = {active_target_high_word, active_target_low_word};
  wire [31:0] tgt = {target_position_high_word, target_position_low_word};
  // Words are frozen while the request is up, so this is the taken value
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) cap_q <= '0;
    else if (!ry[`BIT_TGT_REQ]) cap_q <= tgt;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_req_rise;
    $rose(ry[`BIT_TGT_REQ]);
  endsequence
  sequence s_done_up;
    $rose(rx[`BIT_TGT_DONE]);
  endsequence
  a_spare_ry_low: assert property (
    (ry & 64'hfb5e_ffff_ffff_ffff) == '0)
    else $error("spare request bit driven");
  a_spare_rx_low: assert property (
    (rx & 64'hfffc_ffff_ffff_ffff) == '0)
    else $error("spare status bit driven");
  a_req_answer: assert property (
    s_req_rise |-> ##[1:3] rx[`BIT_TGT_DONE])
    else $error("receipt not reported in time");
  a_done_holds: assert property (
    rx[`BIT_TGT_DONE] && ry[`BIT_TGT_REQ] |=> rx[`BIT_TGT_DONE])
    else $error("receipt dropped early");
  a_done_clears: assert property (
    rx[`BIT_TGT_DONE] && !ry[`BIT_TGT_REQ]
      |=> !rx[`BIT_TGT_DONE] && !rx[`BIT_TGT_REJ])
    else $error("flags not cleared after release");
  a_rej_with_done: assert property (
    rx[`BIT_TGT_REJ] |-> rx[`BIT_TGT_DONE])
    else $error("rejected without receipt");
  a_active_moves: assert property (
    $changed(act) |-> $rose(rx[`BIT_TGT_DONE]) && !rx[`BIT_TGT_REJ])
    else $error("active target moved without accept");
  a_accept_copy: assert property (
    s_done_up ##0 !rx[`BIT_TGT_REJ] |-> act == cap_q)
    else $error("accepted target differs from words");
  a_reject_keep: assert property (
    s_done_up ##0 rx[`BIT_TGT_REJ] |-> $stable(act))
    else $error("rejected target applied");
  a_words_hold: assert property (
    ry[`BIT_TGT_REQ] |-> $stable(tgt))
    else $error("target words changed during request");
endmodule

// ===== verification/stop_position_command_port_tb_top.sv
// Testbench joining master and drive ends over the link
`timescale 1ns/100ps
`include "stop_cmd_defines.svh"
module stop_position_command_port_tb_top;
  import stop_cmd_pkg::*;
  logic clk_sys = 0;
  logic arst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e;
  logic vector_ctrl = 0;
  logic running = 0;
  logic decelerating = 0;
  pos_t lim_a = 32'sd1000;
  pos_t lim_b = -32'sd1000;
  pos_t reach_min = '0;
  pos_t reach_max = 32'sd100;
  pos_t dual_fb = '0;
  pos_t filt = '0;
  pos_t active_target;
  logic target_update, acc_req, dec_req, flt_req;
  int err_total = 0;
  int n_checks = 0;
  int n_upd = 0;
  stop_link_if link_if();
  always #25 clk_sys = ~clk_sys;
  // Accept pulses stand one cycle, so they are counted as they pass
  always @(posedge clk_sys) begin
    if (target_update === 1'b1) begin
      n_upd <= n_upd + 1;
    end
  end
  stop_cmd_master i_stop_cmd_master (.clk_sys(clk_sys), .arst_n(arst_n),
    .link(link_if.master), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  stop_cmd_device i_stop_cmd_device (.clk_sys(clk_sys), .arst_n(arst_n),
    .link(link_if.device), .travel_limit_one(lim_a),
    .travel_limit_two(lim_b), .vector_ctrl(vector_ctrl),
    .dual_fb_position(dual_fb), .filter_position(filt),
    .running(running), .decelerating(decelerating),
    .reach_min(reach_min), .reach_max(reach_max),
    .active_target(active_target), .target_update(target_update),
    .accel_write_request(acc_req), .decel_write_request(dec_req),
    .fault_clear_request(flt_req));
  stop_link_checker i_stop_link_checker (.clk_sys(clk_sys),
    .arst_n(arst_n), .ry(link_if.ry), .rx(link_if.rx),
    .target_position_low_word(link_if.target_position_low_word),
    .target_position_high_word(link_if.target_position_high_word),
    .active_target_low_word(link_if.active_target_low_word),
    .active_target_high_word(link_if.active_target_high_word));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
      err_total++;
    end
  endtask
  // One APB transfer; waits for pready with a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) begin
      err_total++;
      report_and_stop();
    end
  endtask
  // Commit a target and poll until done; status left in q
  task automatic commit(input logic [31:0] v);
    int n;
    apb(1, `OFS_TARGET, v);
    apb(1, `OFS_CTRL, 32'h1);
    n = 0;
    do begin
      apb(0, `OFS_STATUS, '0);
      n++;
    end while (q[`ST_DONE] !== 1'b1 && n < 30);
    if (n >= 30) begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic t_range;
    commit(32'hffff_fc18);
    chk(q, 32'h2);
    apb(0, `OFS_ACTIVE, '0);
    chk(q, 32'hffff_fc18);
    chk(active_target, 32'hffff_fc18);
    commit(32'd1001);
    chk(q, 32'h6);
    apb(0, `OFS_ACTIVE, '0);
    chk(q, 32'hffff_fc18);
    commit(32'h0001_03e8 - 32'h0001_0000);
    chk(q, 32'h2);
    chk(n_upd, 32'd2);
  endtask
  task automatic t_motion;
    decelerating <= 1;
    commit(32'd5);
    chk(q, 32'h6);
    decelerating <= 0;
    running <= 1;
    commit(32'd200);
    chk(q, 32'h6);
    commit(32'd50);
    chk(q, 32'h2);
    chk(n_upd, 32'd3);
    running <= 0;
  endtask
  task automatic t_position;
    dual_fb <= 32'hfff0_0001;
    filt <= 32'h0002_0003;
    for (int i = 0; i < 2; i++) begin
      vector_ctrl <= i[0];
      repeat (3) @(posedge clk_sys);
      apb(0, `OFS_POSITION, '0);
      chk(q, i ? 32'hfff0_0001 : 32'h0002_0003);
      chk({link_if.present_position_high_word,
           link_if.present_position_low_word},
          i ? 32'hfff0_0001 : 32'h0002_0003);
    end
  endtask
  task automatic t_aux;
    apb(1, `OFS_AUX, 32'h7);
    repeat (2) @(posedge clk_sys);
    chk(link_if.ry[63:48], 16'h04a0);
    chk({acc_req, dec_req, flt_req}, 3'b111);
    apb(1, `OFS_AUX, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({acc_req, dec_req, flt_req}, 3'b000);
    apb(0, 8'h18, '0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1;
    t_range();
    t_motion();
    t_position();
    t_aux();
    report_and_stop();
  end
endmodule
